/* inc/spi_defines.svh */
// Register offsets, field positions and reset values of the serial engine
`ifndef SPI_DEFINES_SVH
`define SPI_DEFINES_SVH

// Byte addresses on the register bus
`define SPI_ADDR_CLKDIV 8'h00
`define SPI_ADDR_CONFIG 8'h04
`define SPI_ADDR_COMMAND 8'h08
`define SPI_ADDR_STATUS 8'h0C
`define SPI_ADDR_TXDATA 8'h10
`define SPI_ADDR_RXDATA 8'h14

// Reset values
`define SPI_RST_CLKDIV 16'h0001
`define SPI_RST_CONFIG 32'h0000_0000
`define SPI_RST_SELECTS 3'b111

// Half period is divider plus one system clocks; a divider of zero counts as one
`define SPI_DIV_MIN 16'h0001

// Per-select configuration byte, select n at bits 8n+7..8n; loopback is word bit 24
`define SPI_CFG_CPOL 0
`define SPI_CFG_CPHA 1
`define SPI_CFG_CSPOL 2
`define SPI_CFG_DELAY 3
`define SPI_CFG_LOOP 24

// Command word fields
`define SPI_CMD_FRAME 0
`define SPI_CMD_SEL 16
`define SPI_CMD_LEN 18

// Status word fields
`define SPI_STAT_BUSY 0
`define SPI_STAT_TXRDY 1
`define SPI_STAT_RXVLD 2
`define SPI_STAT_LEFT 16

`endif

/* inc/spi_pkg.sv */
// Types of the serial master engine
package spi_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD,
    ST_LOAD,
    ST_SHIFT,
    ST_STORE,
    ST_TAIL
  } eng_state_t;

  typedef struct packed {
    eng_state_t state;
    logic [15:0] divider;
    logic [31:0] cfgWord;
    logic [1:0] sel;
    logic [4:0] charLen;
    logic [11:0] framesLeft;
    logic [15:0] halfCnt;
    logic phase;
    logic [5:0] bitsLeft;
    logic [2:0] leadLeft;
    logic [31:0] txShift;
    logic [31:0] rxShift;
    logic mosi;
    logic sclk;
    logic [2:0] cs;
    logic inSync1;
    logic inSync2;
    logic ack;
    logic [31:0] rdData;
  } engine_t;

endpackage

/* inc/stream_if.sv */
// Valid/ready word stream between the engine and its buffers
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 32);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

/* src/pair_buffer.sv */
// Small valid/ready buffer, two entries by default
`timescale 1ns/1ps
module pair_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Streams
  stream_if.snk fill,
  stream_if.src drain
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] rdPtr;
    logic [PW-1:0] wrPtr;
    logic [CW-1:0] count;
  } buf_t;

  buf_t s;
  buf_t next_s;
  logic push;
  logic pop;

  assign fill.ready = (s.count != CW'(DEPTH));
  assign drain.valid = (s.count != '0);
  assign drain.data = s.mem[s.rdPtr];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wrPtr] = fill.data;
      next_s.wrPtr = (s.wrPtr == PW'(DEPTH - 1)) ? '0 : s.wrPtr + 1'b1;
    end
    if (pop) begin
      next_s.rdPtr = (s.rdPtr == PW'(DEPTH - 1)) ? '0 : s.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'b1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

/* src/spi_master_mode_engine.sv */
// Serial master engine with classic Wishbone registers
`timescale 1ns/1ps
`include "spi_defines.svh"

// Notes on behaviour
// - Each character is one to thirty-two bits, exactly that many shift.
// - Each select line has its own active level, held for the frame.
// - Polarity zero with phase zero gives mode 0.
// - Polarity zero with phase one gives mode 1.
// - Mode 0 samples on the rising edge and drives after the falling.
// - Mode 1 samples on the falling edge and drives after the rising.
// - Mode 2 samples on the falling edge and drives after the rising.
// - Mode 3 samples on the rising edge and drives after the falling.
// - Zero to three serial clocks pass from select active to data.
// - The serial clock period is never below four system clocks.
// - Master only, driving clock and selects, for three slaves.
// - A frame holds one to 4096 characters under one selection.
// - Loopback feeds transmitted data back into the receive path.
module spi_master_mode_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial pins
  output logic serialClock,
  output logic [2:0] periphSelectLine,
  output logic serialDataOut,
  input wire logic serialDataIn
);

  spi_pkg::engine_t s;
  spi_pkg::engine_t next_s;

  stream_if #(.WIDTH(32)) txFill();
  stream_if #(.WIDTH(32)) txDrain();
  stream_if #(.WIDTH(32)) rxFill();
  stream_if #(.WIDTH(32)) rxDrain();

  logic req;
  logic busRead;
  logic busWrite;
  logic [31:0] wmask;
  logic [7:0] cfg;
  logic [7:0] newCfg;
  logic [1:0] cmdSel;
  logic [15:0] div;
  logic halfDone;
  logic dataIn;
  logic [31:0] loaded;

  //////////////////////////////////////////////////////////////////////////
  // Buffers in the data path

  pair_buffer #(
    .WIDTH(32),
    .DEPTH(2)
  ) txBuffer (
    .clk(clk),
    .sys_rst(sys_rst),
    .fill(txFill.snk),
    .drain(txDrain.src)
  );

  pair_buffer #(
    .WIDTH(32),
    .DEPTH(2)
  ) rxBuffer (
    .clk(clk),
    .sys_rst(sys_rst),
    .fill(rxFill.snk),
    .drain(rxDrain.src)
  );

  //////////////////////////////////////////////////////////////////////////
  // Bus strobes and stream handshakes

  assign req = wb_cyc_i && wb_stb_i && !s.ack;
  assign busRead = req && !wb_we_i;
  assign busWrite = req && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Writes to a full transmit buffer are dropped; software polls ready
  assign txFill.valid = busWrite && (wb_adr_i == `SPI_ADDR_TXDATA);
  assign txFill.data = wb_dat_i;
  assign txDrain.ready = (s.state == spi_pkg::ST_LOAD);
  // Engine stalls in the store state until the receive buffer has room
  assign rxFill.valid = (s.state == spi_pkg::ST_STORE);
  assign rxFill.data = s.rxShift & (32'hFFFF_FFFF >> (~s.charLen));
  assign rxDrain.ready = busRead && (wb_adr_i == `SPI_ADDR_RXDATA);

  //////////////////////////////////////////////////////////////////////////
  // Per-select settings and timing

  assign cfg = s.cfgWord[{s.sel, 3'b000} +: 8];
  assign cmdSel = wb_dat_i[`SPI_CMD_SEL +: 2];
  assign newCfg = s.cfgWord[{cmdSel, 3'b000} +: 8];
  assign div = (s.divider < `SPI_DIV_MIN) ? `SPI_DIV_MIN : s.divider;
  assign halfDone = (s.halfCnt == 16'h0000);
  assign dataIn = s.cfgWord[`SPI_CFG_LOOP] ? s.mosi : s.inSync2;
  assign loaded = txDrain.data << (~s.charLen);

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.inSync1 = serialDataIn;
    next_s.inSync2 = s.inSync1;

    // Register access, one wait state
    if (req) begin
      next_s.ack = 1'b1;
      next_s.rdData = 32'h0000_0000;
      case (wb_adr_i)
        `SPI_ADDR_CLKDIV: begin
          if (wb_we_i) begin
            next_s.divider = (s.divider & ~wmask[15:0]) |
                             (wb_dat_i[15:0] & wmask[15:0]);
          end else begin
            next_s.rdData = {16'h0000, s.divider};
          end
        end
        `SPI_ADDR_CONFIG: begin
          if (wb_we_i) begin
            next_s.cfgWord = (s.cfgWord & ~wmask) | (wb_dat_i & wmask);
          end else begin
            next_s.rdData = s.cfgWord;
          end
        end
        `SPI_ADDR_COMMAND: begin
          if (!wb_we_i) begin
            next_s.rdData = {9'h000, s.charLen, s.sel, 4'h0, s.framesLeft};
          end
        end
        `SPI_ADDR_STATUS: begin
          if (!wb_we_i) begin
            next_s.rdData[`SPI_STAT_BUSY] = (s.state != spi_pkg::ST_IDLE);
            next_s.rdData[`SPI_STAT_TXRDY] = txFill.ready;
            next_s.rdData[`SPI_STAT_RXVLD] = rxDrain.valid;
            next_s.rdData[`SPI_STAT_LEFT +: 12] = s.framesLeft;
          end
        end
        `SPI_ADDR_RXDATA: begin
          if (!wb_we_i && rxDrain.valid) begin
            next_s.rdData = rxDrain.data;
          end
        end
        default: begin
          next_s.rdData = 32'h0000_0000;
        end
      endcase
    end

    // Serial engine
    case (s.state)
      spi_pkg::ST_IDLE: begin
        next_s.sclk = cfg[`SPI_CFG_CPOL];
        // Select code three names no slave and is ignored
        if (busWrite && (wb_adr_i == `SPI_ADDR_COMMAND) &&
            (cmdSel != 2'd3)) begin
          next_s.sel = cmdSel;
          next_s.charLen = wb_dat_i[`SPI_CMD_LEN +: 5];
          next_s.framesLeft = wb_dat_i[`SPI_CMD_FRAME +: 12];
          next_s.halfCnt = div;
          next_s.leadLeft = {newCfg[`SPI_CFG_DELAY +: 2], 1'b0};
          next_s.sclk = newCfg[`SPI_CFG_CPOL];
          next_s.state = spi_pkg::ST_LEAD;
        end
      end
      spi_pkg::ST_LEAD: begin
        if (s.leadLeft == 3'd0) begin
          next_s.state = spi_pkg::ST_LOAD;
        end else if (halfDone) begin
          next_s.leadLeft = s.leadLeft - 3'd1;
          next_s.halfCnt = div;
        end else begin
          next_s.halfCnt = s.halfCnt - 16'h0001;
        end
      end
      spi_pkg::ST_LOAD: begin
        if (txDrain.valid) begin
          next_s.txShift = loaded;
          if (!cfg[`SPI_CFG_CPHA]) begin
            next_s.mosi = loaded[31];
          end
          next_s.bitsLeft = {1'b0, s.charLen} + 6'd1;
          next_s.halfCnt = div;
          next_s.phase = 1'b0;
          next_s.state = spi_pkg::ST_SHIFT;
        end
      end
      spi_pkg::ST_SHIFT: begin
        if (!halfDone) begin
          next_s.halfCnt = s.halfCnt - 16'h0001;
        end else begin
          next_s.halfCnt = div;
          if (!s.phase) begin
            // Leading edge: rising for polarity zero, falling for one
            next_s.phase = 1'b1;
            next_s.sclk = ~cfg[`SPI_CFG_CPOL];
            if (!cfg[`SPI_CFG_CPHA]) begin
              next_s.rxShift = {s.rxShift[30:0], dataIn};
            end else begin
              next_s.mosi = s.txShift[31];
            end
          end else begin
            // Trailing edge back to idle level
            next_s.phase = 1'b0;
            next_s.sclk = cfg[`SPI_CFG_CPOL];
            if (cfg[`SPI_CFG_CPHA]) begin
              next_s.rxShift = {s.rxShift[30:0], dataIn};
            end
            next_s.txShift = {s.txShift[30:0], 1'b0};
            next_s.bitsLeft = s.bitsLeft - 6'd1;
            if (s.bitsLeft == 6'd1) begin
              next_s.state = spi_pkg::ST_STORE;
            end else if (!cfg[`SPI_CFG_CPHA]) begin
              next_s.mosi = s.txShift[30];
            end
          end
        end
      end
      spi_pkg::ST_STORE: begin
        if (rxFill.ready) begin
          if (s.framesLeft == 12'h000) begin
            next_s.halfCnt = div;
            next_s.state = spi_pkg::ST_TAIL;
          end else begin
            next_s.framesLeft = s.framesLeft - 12'h001;
            next_s.state = spi_pkg::ST_LOAD;
          end
        end
      end
      spi_pkg::ST_TAIL: begin
        // Half a clock of select hold after the last edge
        if (halfDone) begin
          next_s.state = spi_pkg::ST_IDLE;
        end else begin
          next_s.halfCnt = s.halfCnt - 16'h0001;
        end
      end
      default: begin
        next_s.state = spi_pkg::ST_IDLE;
      end
    endcase

    // Select lines at their own polarity
    for (int i = 0; i < 3; i++) begin
      if ((next_s.state != spi_pkg::ST_IDLE) && (next_s.sel == 2'(i))) begin
        next_s.cs[i] = next_s.cfgWord[i * 8 + `SPI_CFG_CSPOL];
      end else begin
        next_s.cs[i] = ~next_s.cfgWord[i * 8 + `SPI_CFG_CSPOL];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.state <= spi_pkg::ST_IDLE;
      s.divider <= `SPI_RST_CLKDIV;
      s.cfgWord <= `SPI_RST_CONFIG;
      s.cs <= `SPI_RST_SELECTS;
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdData;
  assign serialClock = s.sclk;
  assign periphSelectLine = s.cs;
  assign serialDataOut = s.mosi;

endmodule

/* test/spi_assertions.sv */
// Port-level checks on the serial master engine
`timescale 1ns/1ps
module spi_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Serial pins
  input wire logic serialClock,
  input wire logic [2:0] periphSelectLine,
  input wire logic serialDataOut,
  input wire logic serialDataIn
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence sReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence sTaken;
    sReq ##1 wb_ack_o;
  endsequence
  ////////////////////////////////////////
  a_ack_answer:
  assert property (sReq |=> wb_ack_o) else $error("ack late");
  a_ack_single:
  assert property (sTaken |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause:
  assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  a_unmapped_zero:
  assert property (wb_ack_o && !wb_we_i
    && (wb_adr_i > 8'h14 || wb_adr_i[1:0] != 2'h0)
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read data");
  // Half period of two clocks at least keeps the period at four
  a_sclk_half:
  assert property ($changed(serialClock) |=> $stable(serialClock))
    else $error("serial clock half period short");
  a_sclk_still:
  assert property ($changed(periphSelectLine) |=> $stable(serialClock))
    else $error("clock edge right at select change");
  a_sel_single:
  assert property ($onehot0(periphSelectLine ^ $past(periphSelectLine)))
    else $error("several selects moved together");
  a_sel_hold:
  assert property ($changed(periphSelectLine)
    |=> $stable(periphSelectLine) [*2]) else $error("select glitch");
endmodule

bind spi_master_mode_engine spi_assertions chk (
  .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .serialClock(serialClock),
  .periphSelectLine(periphSelectLine), .serialDataOut(serialDataOut),
  .serialDataIn(serialDataIn));

/* test/serial_slave_model.sv */
// Behavioural serial slave on one select line
`timescale 1ns/1ps
module serial_slave_model (
  // Link
  input wire logic sclk,
  input wire logic csActive,
  input wire logic mosi,
  output logic miso,
  // Setup from the bench
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [5:0] len,
  input wire logic [31:0] reply,
  output logic [31:0] got
);
  int idx = 0;
  realtime tSel = 0;
  initial miso = 1'b0;
  initial got = 32'h0000_0000;
  always @(posedge csActive) begin
    tSel = $realtime;
    idx = len - 1;
    got = 32'h0000_0000;
    miso = reply[idx];
  end
  // Released line shows the inverse, never a stale bit
  always @(negedge csActive) miso = ~miso;
  // Idle level set with the select is not an edge
  always @(sclk) begin
    if (csActive && $realtime != tSel) begin
      if ((sclk != cpol) ^ cpha) begin
        got = {got[30:0], mosi};
        if (cpha) idx = (idx == 0) ? len - 1 : idx - 1;
      end else begin
        if (!cpha) idx = (idx == 0) ? len - 1 : idx - 1;
        miso = reply[idx];
      end
    end
  end
endmodule

/* test/test_spi_master_mode_engine.sv */
// Self-checking bench for the serial master engine
`timescale 1ns/1ps
module test_spi_master_mode_engine;
  logic clk = 0, sys_rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 0, wb_dat_o, reply = 0, got, q;
  logic wb_ack_o, serialClock, serialDataOut, serialDataIn, csAct;
  logic [2:0] periphSelectLine;
  logic [1:0] selIdx = 0;
  logic cpol = 0, cpha = 0, csHigh = 0, edged = 0, lb = 0, csPrev = 0;
  logic [5:0] len = 8;
  int miscompares = 0, checked = 0, cycles = 0, lead = 0, lead0 = 0;
  always #12.5 clk = ~clk;
  assign csAct = periphSelectLine[selIdx] == csHigh;
  spi_master_mode_engine DUT (.clk(clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serialClock(serialClock),
    .periphSelectLine(periphSelectLine), .serialDataOut(serialDataOut),
    .serialDataIn(serialDataIn));
  serial_slave_model slave (.sclk(serialClock), .csActive(csAct),
    .mosi(serialDataOut), .miso(serialDataIn), .cpol(cpol), .cpha(cpha),
    .len(len), .reply(reply), .got(got));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, act);
    checked++;
    if (act !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, act);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic test_done;
    $display("Compares %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One frame of c+1 characters of n+1 bits on select s
  task automatic frame(input logic [1:0] s, input logic [4:0] cfg,
      input logic [4:0] n, input logic c, input logic [31:0] tx, rp);
    logic [31:0] m;
    int k;
    m = 32'((64'd1 << (n + 1)) - 1);
    {selIdx, cpol, cpha, csHigh} = {s, cfg[0], cfg[1], s == 2'd1};
    {len, reply} = {6'(n) + 6'd1, rp};
    // Select 1 stays active high for the whole run
    bus(1, 8'h04, {7'h0, lb, 24'h00_0400} | (32'(cfg) << (8 * s)));
    bus(1, 8'h10, tx);
    if (c) bus(1, 8'h10, tx);
    bus(1, 8'h08, {9'h0, n, s, 4'h0, 12'(c)});
    bus(0, 8'h0C, 0);
    check("select active", 32'(csHigh), 32'(periphSelectLine[s]));
    for (k = 0; k < 300 && q[0] !== 1'b0; k++) bus(0, 8'h0C, 0);
    check("select idle", 32'(!csHigh), 32'(periphSelectLine[s]));
    check("idle clock", 32'(cpol), 32'(serialClock));
    bus(0, 8'h14, 0);
    check("rx word", (lb ? tx : rp) & m, q);
    if (c) bus(0, 8'h14, 0);
    if (c) check("rx second", rp & m, q);
    if (!lb) check("tx bits", tx & m, got & m);
  endtask
  ////////////////////////////////////////
  always @(posedge clk) begin
    csPrev <= csAct;
    cycles <= cycles + 1;
    if (csAct && !csPrev) begin
      lead <= 0;
      edged <= 1'b0;
    end else if (csAct && serialClock !== cpol) edged <= 1'b1;
    else if (csAct && !edged) lead <= lead + 1;
    if (cycles == 40000) begin
      miscompares++;
      test_done;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(0, 8'h00, 0);
    check("divider reset", 32'h0000_0001, q);
    bus(0, 8'h04, 0);
    check("config reset", 32'h0000_0000, q);
    bus(0, 8'h18, 0);
    check("unmapped read", 32'h0000_0000, q);
    // Divider 3 leaves the slave time to pass the input synchronizer
    bus(1, 8'h00, 32'h0000_0003);
    for (int i = 0; i < 4; i++) begin
      frame(2'(i % 3), {3'h0, 1'(i), 1'(i >> 1)}, 5'd7, 1'b0,
        32'h0000_00A5 + 32'(i), 32'h0000_003C);
    end
    frame(0, 5'h00, 5'd0, 0, 32'h0000_0001, 32'h0000_0000);
    frame(2, 5'h03, 5'd31, 0, 32'hC3A5_0F96, 32'h5A0F_E187);
    lead0 = lead;
    frame(1, 5'h18, 5'd7, 1, 32'h0000_0081, 32'h0000_007E);
    check("lead delay", 32'(lead0 + 24), 32'(lead));
    lb = 1'b1;
    bus(1, 8'h00, 32'h0000_0000);
    frame(0, 5'h02, 5'd15, 0, 32'h0000_BEEF, 32'h0000_1234);
    test_done;
  end
endmodule
